// >>> logic/pewu_pkg.sv
// Constants, state types and pin layout of the power event and wake unit
package pewu_pkg;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int unsigned CLK_HZ       = 25_000_000;
    localparam int unsigned RING_MIN_MS  = 4;
    localparam int unsigned THERMAL_ALARM_IN_MIN_S  = 2;
    localparam int unsigned RST_REL_MS   = 24;
    localparam int unsigned LED_BLINK_HZ = 1;
    localparam int unsigned EDGE_MIN_CYC = 1;
    localparam int unsigned RING_MIN_CYC = (CLK_HZ / 1000) * RING_MIN_MS;
    localparam int unsigned THERMAL_ALARM_IN_MIN_CYC = CLK_HZ * THERMAL_ALARM_IN_MIN_S;
    localparam int unsigned RST_REL_CYC  = (CLK_HZ / 1000) * RST_REL_MS;
    localparam int unsigned LED_HALF_CYC = CLK_HZ / (2 * LED_BLINK_HZ);

    // ********************************************************************
    // Pin and status layout
    // ********************************************************************
    localparam int SRC_BTN   = 0;
    localparam int SRC_WAKE  = 1;
    localparam int SRC_RING  = 2;
    localparam int SRC_THERMAL_ALARM_IN = 3;
    localparam int SRC_EXT   = 4;
    localparam int SRC_ALERT = 5;
    localparam int STS_OVR   = 6;
    localparam int PIN_PGOOD = 6;
    localparam int N_SRC     = 6;
    localparam int N_STS     = 7;
    localparam int N_PIN     = 7;
    // Ring and power good are active high, the rest active low
    localparam logic [N_PIN-1:0] PIN_ACT_LOW = 7'h3B;
    localparam logic [N_STS-1:0] STS_RST     = 7'h00;

    // ********************************************************************
    // Event routing codes and power state
    // ********************************************************************
    typedef logic [2:0] pewu_route_t;
    localparam pewu_route_t RT_NONE  = 3'h0;
    localparam pewu_route_t RT_WAKE  = 3'h1;
    localparam pewu_route_t RT_SLEEP = 3'h2;
    localparam pewu_route_t RT_SCI   = 3'h3;
    localparam pewu_route_t RT_SMI   = 3'h4;
    localparam pewu_route_t RT_GPE   = 3'h5;

    typedef enum logic [1:0] {PWR_OFF, PWR_WORK, PWR_SLEEP} pewu_pwr_e;

endpackage

// >>> logic/pewu_evt_if.sv
// Qualified event carrier between an input filter and the event unit
`timescale 1ns/1ps
interface pewu_evt_if;
    logic act;
    logic hit;
    modport src (output act, output hit);
    modport dst (input act, input hit);
endinterface

// >>> logic/pewu_filter.sv
// Pin synchroniser and minimum-duration qualifier for one event input
`timescale 1ns/1ps
module pewu_filter
    import pewu_pkg::*;
#(
    parameter int unsigned HOLD_CYC = EDGE_MIN_CYC,
    parameter bit          ACT_LOW  = 1'b1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Raw pin
    input wire logic pin,
    // Qualified event
    pewu_evt_if.src  ev
);
    localparam int CW = $clog2(HOLD_CYC + 2);
    localparam logic [CW-1:0] HOLD_N = CW'(HOLD_CYC);
    localparam logic [CW-1:0] SAT_N  = CW'(HOLD_CYC + 1);
    localparam logic          IDLE   = ACT_LOW;

    if (HOLD_CYC < 1) begin : g_chk
        $error("pewu_filter: HOLD_CYC must be at least 1");
    end

    logic          s1_r;
    logic          s2_r;
    logic          s3_r;
    logic          lvl_r;
    logic [CW-1:0] cnt_r;
    logic          hit_r;
    logic          act;

    // ********************************************************************
    // Synchroniser
    // ********************************************************************
    // A level change counts only once two late stages agree
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s1_r  <= IDLE;
            s2_r  <= IDLE;
            s3_r  <= IDLE;
            lvl_r <= IDLE;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                lvl_r <= s3_r;
            end
        end
    end

    assign act = lvl_r ^ ACT_LOW;

    // ********************************************************************
    // Duration qualifier
    // ********************************************************************
    // Event needs more than HOLD_CYC active cycles; shorter pulses vanish
    always_ff @(posedge sys_clk) begin
        if (rst || !act) begin
            cnt_r <= '0;
        end else if (cnt_r != SAT_N) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hit_r <= 1'b0;
        end else begin
            hit_r <= act && (cnt_r == HOLD_N);
        end
    end

    assign ev.act = act;
    assign ev.hit = hit_r;

    // ********************************************************************
    // Checks
    // ********************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    hit_hold_a: assert property (hit_r |-> $past(act) && $past(cnt_r) == HOLD_N)
        else $error("event qualified before its hold time");
    hit_once_a: assert property (hit_r |=> !hit_r)
        else $error("qualified event lasted more than one cycle");

endmodule

// >>> logic/pewu_top.sv
// Power event, wake, LED, supply control and reset release unit
`timescale 1ns/1ps
module pewu_top
    import pewu_pkg::*;
#(
    parameter int unsigned RING_HOLD  = RING_MIN_CYC,
    parameter int unsigned THERMAL_ALARM_IN_HOLD = THERMAL_ALARM_IN_MIN_CYC,
    parameter int unsigned RST_HOLD   = RST_REL_CYC,
    parameter int unsigned LED_HALF   = LED_HALF_CYC
) (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // Event pins
    input  wire logic                   power_button_in,
    input  wire logic                   wake_event_in,
    input  wire logic                   line_call_in,
    input  wire logic                   thermal_alarm_in,
    input  wire logic                   external_mgmt_event_in,
    input  wire logic                   sideband_alert_in,
    input  wire logic                   main_power_good,
    // Control from the system
    input  wire logic [N_SRC-1:0]       src_en,
    input  wire pewu_route_t [N_SRC-1:0] src_route,
    input  wire logic [N_STS-1:0]       status_clr,
    input  wire logic                   power_off_req,
    // Supply and indicator, open drain
    output logic                        supply_on_ctl_n,
    output logic                        supply_on_oe,
    output logic                        sleep_indicator_led,
    output logic                        sleep_indicator_oe,
    // Interrupts and status
    output logic                        os_control_irq,
    output logic                        mgmt_mode_irq,
    output logic                        general_event_irq,
    output logic [N_STS-1:0]            event_status,
    output logic                        cpu_throttle,
    // Resets
    output logic                        cpu_reset,
    output logic                        bus_reset_n
);
    localparam int RCW = $clog2(RST_HOLD + 1);
    localparam int LCW = $clog2(LED_HALF + 1);
    localparam logic [RCW-1:0] RST_N  = RCW'(RST_HOLD);
    localparam logic [LCW-1:0] LED_N1 = LCW'(LED_HALF - 1);
    localparam int unsigned HOLD_TAB [N_PIN] = '{EDGE_MIN_CYC, EDGE_MIN_CYC,
        RING_HOLD, THERMAL_ALARM_IN_HOLD, EDGE_MIN_CYC, EDGE_MIN_CYC, EDGE_MIN_CYC};

    if (RING_HOLD < 1 || THERMAL_ALARM_IN_HOLD < 1 || RST_HOLD < 1 || LED_HALF < 1)
    begin : g_chk
        $error("pewu_top: every hold count must be at least 1");
    end

    logic [N_PIN-1:0] pin_raw;
    logic [N_PIN-1:0] act;
    logic [N_PIN-1:0] hit;
    logic             thermal_alarm_in_d_r;
    logic [N_STS-1:0] set_v;
    logic [N_STS-1:0] status_r;
    logic             wake_any;
    logic             sleep_req;
    pewu_pwr_e        state_r;
    logic             supply_n_r;
    logic             supply_oe_r;
    logic             led_r;
    logic             led_oe_r;
    logic [LCW-1:0]   blink_cnt_r;
    logic             blink_ph_r;
    logic             sci_r;
    logic             smi_r;
    logic             gpe_r;
    logic             sci_nxt;
    logic             smi_nxt;
    logic             gpe_nxt;
    logic             throttle_r;
    logic [RCW-1:0]   rel_cnt_r;
    logic             cpu_rst_r;
    logic             bus_rst_n_r;

    // ********************************************************************
    // Input filters
    // ********************************************************************
    assign pin_raw = {main_power_good, sideband_alert_in,
                      external_mgmt_event_in, thermal_alarm_in,
                      line_call_in, wake_event_in, power_button_in};

    for (genvar i = 0; i < N_PIN; i++) begin : g_pin
        pewu_evt_if ev ();
        pewu_filter #(
            .HOLD_CYC (HOLD_TAB[i]),
            .ACT_LOW  (PIN_ACT_LOW[i])
        ) u_flt (
            .sys_clk (sys_clk),
            .rst     (rst),
            .pin     (pin_raw[i]),
            .ev      (ev)
        );
        assign act[i] = ev.act;
        assign hit[i] = ev.hit;
    end

    // ********************************************************************
    // Sticky event status
    // ********************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            thermal_alarm_in_d_r <= 1'b0;
        end else begin
            thermal_alarm_in_d_r <= act[SRC_THERMAL_ALARM_IN];
        end
    end

    // Thermal pending uses the alarm's leading edge; its long hit is override
    always_comb begin
        set_v            = hit[N_STS-1:0] & {1'b0, src_en};
        set_v[SRC_THERMAL_ALARM_IN] = src_en[SRC_THERMAL_ALARM_IN] && act[SRC_THERMAL_ALARM_IN]
                           && !thermal_alarm_in_d_r;
        set_v[STS_OVR]   = hit[SRC_THERMAL_ALARM_IN];
    end

    // Set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status_r <= STS_RST;
        end else begin
            status_r <= (status_r & ~status_clr) | set_v;
        end
    end

    // ********************************************************************
    // Power state
    // ********************************************************************
    assign wake_any = (src_en[SRC_BTN] && hit[SRC_BTN])
                    || (src_en[SRC_WAKE] && hit[SRC_WAKE])
                    || (src_en[SRC_RING] && hit[SRC_RING])
                    || (src_en[SRC_ALERT] && hit[SRC_ALERT])
                    || (src_en[SRC_EXT] && hit[SRC_EXT]
                        && src_route[SRC_EXT] == RT_WAKE);
    assign sleep_req = (src_en[SRC_BTN] && hit[SRC_BTN])
                    || (src_en[SRC_EXT] && hit[SRC_EXT]
                        && src_route[SRC_EXT] == RT_SLEEP);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= PWR_OFF;
        end else begin
            unique case (state_r)
                PWR_OFF: begin
                    if (wake_any) state_r <= PWR_WORK;
                end
                PWR_WORK: begin
                    if (power_off_req) state_r <= PWR_OFF;
                    else if (sleep_req) state_r <= PWR_SLEEP;
                end
                PWR_SLEEP: begin
                    if (wake_any) state_r <= PWR_WORK;
                end
                // Spare code: fall back to off rather than hang
                default: begin
                    state_r <= PWR_OFF;
                end
            endcase
        end
    end

    // Open drain: pull low to switch the supply on
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            supply_n_r  <= 1'b1;
            supply_oe_r <= 1'b0;
        end else begin
            supply_n_r  <= (state_r == PWR_OFF);
            supply_oe_r <= (state_r != PWR_OFF);
        end
    end

    // ********************************************************************
    // Sleep indicator blink
    // ********************************************************************
    // Phase restarts on each sleep entry so the LED always starts dark
    always_ff @(posedge sys_clk) begin
        if (rst || state_r != PWR_SLEEP) begin
            blink_cnt_r <= '0;
            blink_ph_r  <= 1'b0;
        end else if (blink_cnt_r == LED_N1) begin
            blink_cnt_r <= '0;
            blink_ph_r  <= !blink_ph_r;
        end else begin
            blink_cnt_r <= blink_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            led_r    <= 1'b1;
            led_oe_r <= 1'b0;
        end else begin
            led_oe_r <= (state_r == PWR_SLEEP) && blink_ph_r;
            led_r    <= !((state_r == PWR_SLEEP) && blink_ph_r);
        end
    end

    // ********************************************************************
    // Interrupt routing and throttle
    // ********************************************************************
    always_comb begin
        sci_nxt = 1'b0;
        smi_nxt = 1'b0;
        gpe_nxt = 1'b0;
        for (int i = 0; i < N_SRC; i++) begin
            if (status_r[i]) begin
                sci_nxt = sci_nxt || (src_route[i] == RT_SCI);
                smi_nxt = smi_nxt || (src_route[i] == RT_SMI);
                gpe_nxt = gpe_nxt || (src_route[i] == RT_GPE);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sci_r <= 1'b0;
            smi_r <= 1'b0;
            gpe_r <= 1'b0;
        end else begin
            sci_r <= sci_nxt;
            smi_r <= smi_nxt;
            gpe_r <= gpe_nxt;
        end
    end

    // Throttling holds until the alarm itself goes away; a qualified
    // override is never lost even if the alarm drops in that same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            throttle_r <= 1'b0;
        end else if (hit[SRC_THERMAL_ALARM_IN]) begin
            throttle_r <= 1'b1;
        end else if (!act[SRC_THERMAL_ALARM_IN]) begin
            throttle_r <= 1'b0;
        end
    end

    // ********************************************************************
    // Reset release
    // ********************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst || !act[PIN_PGOOD]) begin
            rel_cnt_r <= '0;
        end else if (rel_cnt_r != RST_N) begin
            rel_cnt_r <= rel_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cpu_rst_r   <= 1'b1;
            bus_rst_n_r <= 1'b0;
        end else begin
            cpu_rst_r   <= !(act[PIN_PGOOD] && rel_cnt_r == RST_N);
            bus_rst_n_r <= act[PIN_PGOOD] && rel_cnt_r == RST_N;
        end
    end

    assign supply_on_ctl_n     = supply_n_r;
    assign supply_on_oe        = supply_oe_r;
    assign sleep_indicator_led = led_r;
    assign sleep_indicator_oe  = led_oe_r;
    assign os_control_irq      = sci_r;
    assign mgmt_mode_irq       = smi_r;
    assign general_event_irq   = gpe_r;
    assign event_status        = status_r;
    assign cpu_throttle        = throttle_r;
    assign cpu_reset           = cpu_rst_r;
    assign bus_reset_n         = bus_rst_n_r;

    // ********************************************************************
    // Checks
    // ********************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    led_dark_a: assert property (state_r != PWR_SLEEP |=> !led_oe_r)
        else $error("indicator driven outside sleep");
    ext_smi_a: assert property (src_en[SRC_EXT] && hit[SRC_EXT]
        && src_route[SRC_EXT] == RT_SMI |-> ##2 smi_r)
        else $error("management event did not raise its interrupt");
    wake_on_a: assert property (state_r == PWR_OFF && src_en[SRC_WAKE]
        && hit[SRC_WAKE] |-> ##2 !supply_n_r && supply_oe_r)
        else $error("wake event did not turn supply on");
    wake_susp_a: assert property (state_r == PWR_SLEEP && src_en[SRC_WAKE]
        && hit[SRC_WAKE] |=> state_r == PWR_WORK)
        else $error("wake event did not leave suspend");
    off_stays_a: assert property (state_r == PWR_OFF && !wake_any
        |=> state_r == PWR_OFF ##1 supply_n_r)
        else $error("supply turned on without an event");
    btn_sleep_a: assert property (state_r == PWR_WORK && !power_off_req
        && src_en[SRC_BTN] && hit[SRC_BTN] |=> state_r == PWR_SLEEP)
        else $error("button did not enter sleep");
    thermal_alarm_in_pend_a: assert property ($rose(act[SRC_THERMAL_ALARM_IN]) && src_en[SRC_THERMAL_ALARM_IN]
        |=> status_r[SRC_THERMAL_ALARM_IN])
        else $error("thermal pending flag not set");
    thermal_alarm_in_ovr_a: assert property (hit[SRC_THERMAL_ALARM_IN] |=> throttle_r
        && status_r[STS_OVR])
        else $error("thermal override not raised");
    alert_wake_a: assert property (state_r == PWR_SLEEP
        && src_en[SRC_ALERT] && hit[SRC_ALERT] |=> state_r == PWR_WORK)
        else $error("alert did not wake the system");
    sticky_a: assert property (status_r[SRC_RING] && !status_clr[SRC_RING]
        |=> status_r[SRC_RING])
        else $error("status flag dropped without clear");
    pgood_rst_a: assert property (!act[PIN_PGOOD]
        |=> cpu_rst_r && !bus_rst_n_r)
        else $error("reset released while power not good");

    wake_off_c: cover property (state_r == PWR_OFF ##1 state_r == PWR_WORK);
    sleep_c: cover property (state_r == PWR_WORK ##1 state_r == PWR_SLEEP);
    blink_c: cover property ($rose(led_oe_r));
    throttle_c: cover property ($rose(throttle_r));

endmodule

// >>> dv/pewu_env_model.sv
// Behavioural model of the supply, button, sensor and wake sources
`timescale 1ns/1ps
module pewu_env_model
    import pewu_pkg::*;
#(
    parameter int PG_DLY = 6
) (
    // Clock
    input  wire logic sys_clk,
    // Supply control, open drain
    input  wire logic supply_on_ctl_n,
    input  wire logic supply_on_oe,
    // Event pins
    output logic      power_button_in,
    output logic      wake_event_in,
    output logic      line_call_in,
    output logic      thermal_alarm_in,
    output logic      external_mgmt_event_in,
    output logic      sideband_alert_in,
    output logic      main_power_good
);
    logic [N_SRC-1:0] act_r  = '0;
    logic             supply_lvl;
    int               pg_cnt = 0;

    // Control line floats up to off when released
    assign supply_lvl = supply_on_oe ? supply_on_ctl_n : 1'b1;
    // Active-low lines rest high on their pull-ups
    assign power_button_in        = ~act_r[SRC_BTN];
    assign wake_event_in          = ~act_r[SRC_WAKE];
    assign line_call_in           = act_r[SRC_RING];
    assign thermal_alarm_in       = ~act_r[SRC_THERMAL_ALARM_IN];
    assign external_mgmt_event_in = ~act_r[SRC_EXT];
    assign sideband_alert_in      = ~act_r[SRC_ALERT];

    // Power good only after the supply has run a while
    always @(posedge sys_clk) begin
        pg_cnt <= supply_lvl ? 0 : pg_cnt + 1;
    end
    assign main_power_good = pg_cnt > PG_DLY;

    task automatic drive(input int idx, input int n);
        @(posedge sys_clk);
        act_r[idx] <= 1'b1;
        repeat (n) @(posedge sys_clk);
        act_r[idx] <= 1'b0;
        // Idle gap so the unit sees the line go inactive
        repeat (8) @(posedge sys_clk);
        #1;
    endtask
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the power event and wake unit
`timescale 1ns/1ps
module testbench
    import pewu_pkg::*;
;
    localparam int RING_H  = 5;
    localparam int THERMAL_ALARM_IN_H = 20;
    localparam int RST_H   = 10;
    localparam int LED_H   = 4;

    logic                    sys_clk       = 1'b0;
    logic                    rst           = 1'b1;
    logic                    power_off_req = 1'b0;
    logic [N_SRC-1:0]        src_en        = '1;
    pewu_route_t [N_SRC-1:0] src_route     = '0;
    logic [N_STS-1:0]        status_clr    = '0;
    logic [N_STS-1:0]        event_status;
    logic power_button_in, wake_event_in, line_call_in, thermal_alarm_in;
    logic external_mgmt_event_in, sideband_alert_in, main_power_good;
    logic supply_on_ctl_n, supply_on_oe, sleep_indicator_led;
    logic sleep_indicator_oe, os_control_irq, mgmt_mode_irq;
    logic general_event_irq, cpu_throttle, cpu_reset, bus_reset_n;
    int                      n_errors      = 0;
    int                      comparisons   = 0;
    int                      cycles        = 0;

    pewu_top #(.RING_HOLD(RING_H), .THERMAL_ALARM_IN_HOLD(THERMAL_ALARM_IN_H),
               .RST_HOLD(RST_H), .LED_HALF(LED_H)) DUT (
        .sys_clk, .rst, .power_button_in, .wake_event_in, .line_call_in,
        .thermal_alarm_in, .external_mgmt_event_in, .sideband_alert_in,
        .main_power_good, .src_en, .src_route, .status_clr, .power_off_req,
        .supply_on_ctl_n, .supply_on_oe, .sleep_indicator_led,
        .sleep_indicator_oe, .os_control_irq, .mgmt_mode_irq,
        .general_event_irq, .event_status, .cpu_throttle, .cpu_reset,
        .bus_reset_n);

    pewu_env_model pm (
        .sys_clk, .supply_on_ctl_n, .supply_on_oe, .power_button_in,
        .wake_event_in, .line_call_in, .thermal_alarm_in,
        .external_mgmt_event_in, .sideband_alert_in, .main_power_good);

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic clr(input logic [N_STS-1:0] m);
        @(posedge sys_clk);
        status_clr <= m;
        @(posedge sys_clk);
        status_clr <= '0;
        cyc(2);
    endtask

    // A dozen cycles covers more than one LED half period
    task automatic blinks(output logic b);
        b = 1'b0;
        repeat (12) begin
            cyc(1);
            if (sleep_indicator_oe === 1'b1) b = 1'b1;
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_power_on;
        int n;
        #1;
        check(supply_on_oe, 0);
        check({cpu_reset, bus_reset_n}, 2'b10);
        pm.drive(SRC_BTN, 3);
        check({supply_on_oe, supply_on_ctl_n}, 2'b10);
        check(event_status, 7'h01);
        n = 0;
        while (main_power_good !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        n = 0;
        while (cpu_reset === 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        check(n > RST_H && n <= RST_H + 6, 1);
        check(bus_reset_n, 1);
        clr(7'h01);
        check(event_status, 0);
        $display("done power on");
    endtask

    task automatic t_sleep_led;
        int n;
        pm.drive(SRC_BTN, 3);
        n = 0;
        while (sleep_indicator_oe !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        check(sleep_indicator_led, 0);
        n = 0;
        while (sleep_indicator_oe === 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        check(n, LED_H);
        check(supply_on_oe, 1);
        clr(7'h01);
        $display("done sleep led");
    endtask

    task automatic t_ring;
        logic b;
        pm.drive(SRC_RING, RING_H - 1);
        check(event_status[SRC_RING], 0);
        pm.drive(SRC_RING, RING_H + 4);
        check(event_status[SRC_RING], 1);
        blinks(b);
        check(b, 0);
        clr(7'h04);
        $display("done ring");
    endtask

    task automatic t_ext_routes;
        pewu_route_t rt [3] = '{RT_SCI, RT_SMI, RT_GPE};
        logic        b;
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            src_route[SRC_EXT] <= rt[i];
            pm.drive(SRC_EXT, 3);
            check({os_control_irq, mgmt_mode_irq, general_event_irq},
                  3'b100 >> i);
            clr(7'h10);
            check(os_control_irq | mgmt_mode_irq | general_event_irq, 0);
        end
        @(posedge sys_clk);
        src_route[SRC_EXT] <= RT_SLEEP;
        pm.drive(SRC_EXT, 3);
        blinks(b);
        check(b, 1);
        @(posedge sys_clk);
        src_route[SRC_EXT] <= RT_WAKE;
        pm.drive(SRC_EXT, 3);
        blinks(b);
        check(b, 0);
        clr(7'h10);
        $display("done management routes");
    endtask

    task automatic t_thermal_alarm_in;
        @(posedge sys_clk);
        src_route[SRC_THERMAL_ALARM_IN] <= RT_SCI;
        pm.drive(SRC_THERMAL_ALARM_IN, 4);
        check({event_status[STS_OVR], event_status[SRC_THERMAL_ALARM_IN]}, 2'b01);
        check({os_control_irq, cpu_throttle}, 2'b10);
        clr(7'h08);
        fork
            pm.drive(SRC_THERMAL_ALARM_IN, THERMAL_ALARM_IN_H + 12);
            begin
                cyc(THERMAL_ALARM_IN_H + 12);
                check(cpu_throttle, 1);
            end
        join
        check(event_status[STS_OVR], 1);
        check(cpu_throttle, 0);
        clr(7'h48);
        $display("done thermal");
    endtask

    task automatic t_alert_wake;
        logic b;
        @(posedge sys_clk);
        src_route[SRC_ALERT] <= RT_SMI;
        src_route[SRC_WAKE] <= RT_GPE;
        pm.drive(SRC_ALERT, 3);
        check(mgmt_mode_irq, 1);
        clr(7'h20);
        pm.drive(SRC_BTN, 3);
        pm.drive(SRC_WAKE, 3);
        check(general_event_irq, 1);
        blinks(b);
        check(b, 0);
        clr(7'h03);
        @(posedge sys_clk);
        power_off_req <= 1'b1;
        src_en[SRC_WAKE] <= 1'b0;
        @(posedge sys_clk);
        power_off_req <= 1'b0;
        cyc(10);
        check({supply_on_oe, cpu_reset}, 2'b01);
        pm.drive(SRC_WAKE, 3);
        check(supply_on_oe, 0);
        @(posedge sys_clk);
        src_en[SRC_WAKE] <= 1'b1;
        pm.drive(SRC_WAKE, 3);
        check({supply_on_oe, supply_on_ctl_n}, 2'b10);
        $display("done alert and wake");
    endtask

    // Ceiling well above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        t_power_on();
        t_sleep_led();
        t_ring();
        t_ext_routes();
        t_thermal_alarm_in();
        t_alert_wake();
        print_verdict();
    end
endmodule
